/* bench/sirc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sirc_assertions
    import sirc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Events and interrupts
    input wire sirc_evt_t evt_i,
    input wire sirc_cause_t reset_cause_i,
    input wire logic brownout_detect_enable_i,
    input wire logic periph_irq_o,
    input wire logic irq_o
);
    logic [1:0] core_q;
    logic [1:0] mask_q;
    wire logic wr_w = psel && penable && pwrite && clk_en_i;
    wire logic rd_w = psel && penable && !pwrite;
    wire logic bank_w = paddr == SIRC_FLAGS_ADDR || paddr == SIRC_ENABLES_ADDR;

    // Shadow of the gating enables, so outputs can be tied to causes
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            core_q <= 2'h0;
        else if (wr_w && paddr == SIRC_CORE_ADDR)
            core_q <= pwdata[7:6];
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            mask_q <= 2'h0;
        else if (wr_w && paddr == SIRC_MASK_ADDR)
            mask_q <= pwdata[1:0];
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence ev_s(logic e);
        e && clk_en_i;
    endsequence
    sequence setup_s(logic [11:0] a);
        psel && !penable && !pwrite && clk_en_i && paddr == a;
    endsequence

    AST_NVM_FLAG: assert property (ev_s(evt_i.nvm_write_done) ##1 setup_s(SIRC_FLAGS_ADDR)
        |=> prdata[4]) else $error("write-done flag not set");
    AST_COL_FLAG: assert property (ev_s(evt_i.collision) ##1 setup_s(SIRC_FLAGS_ADDR)
        |=> prdata[3]) else $error("collision flag not set");
    AST_EN_RW: assert property (wr_w && paddr == SIRC_ENABLES_ADDR ##1 setup_s(SIRC_ENABLES_ADDR)
        |=> prdata[4:3] == $past(pwdata[4:3], 2)) else $error("enable readback wrong");
    AST_RSV_ZERO: assert property (rd_w && bank_w |-> (prdata & ~32'h18) == 32'h0)
        else $error("unimplemented bit read nonzero");
    AST_PWR_ZERO: assert property (rd_w && paddr == SIRC_PWR_ADDR |-> prdata[31:2] == 30'h0)
        else $error("power register upper bits nonzero");
    AST_PERIPH_GATE: assert property (!$past(core_q[0]) |-> !periph_irq_o)
        else $error("peripheral irq without peripheral enable");
    AST_GLOBAL_GATE: assert property ($past(core_q) == 2'h0 && $past(mask_q) == 2'h0
        |-> !irq_o) else $error("irq without any enable");
    AST_RESET_CLR: assert property ($fell(reset_i) |-> !irq_o && !periph_irq_o)
        else $error("irq set after reset");
endmodule : sirc_assertions

bind sirc_top sirc_assertions chk (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .pslverr(pslverr),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .evt_i(evt_i),
    .reset_cause_i(reset_cause_i),
    .brownout_detect_enable_i(brownout_detect_enable_i),
    .periph_irq_o(periph_irq_o),
    .irq_o(irq_o)
);
`default_nettype wire

/* bench/tb_secondary_irq_and_reset_cause.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_secondary_irq_and_reset_cause;
    import sirc_pkg::*;
    logic sys_clk_i = 0, reset_i = 1, clk_en_i = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd_q, lf = 32'h147DE;
    logic pready, pslverr, err_q, periph_irq_o, irq_o, bde = 1;
    sirc_evt_t evt = 2'h0;
    sirc_cause_t cause = SIRC_CAUSE_POR;
    int n_errors = 0, checked = 0;
    logic [7:0] m_fl, m_en, m_co;
    logic [1:0] m_st, m_mk, m_pw;
    localparam logic [11:0] AD [6] = '{SIRC_FLAGS_ADDR, SIRC_ENABLES_ADDR, SIRC_CORE_ADDR,
        SIRC_STAT_ADDR, SIRC_MASK_ADDR, SIRC_PWR_ADDR};
    localparam sirc_cause_t CS [4] = '{SIRC_CAUSE_BROWNOUT, SIRC_CAUSE_WATCHDOG, SIRC_CAUSE_PIN,
        SIRC_CAUSE_POR};
    localparam logic [1:0] PE [4] = '{2'h2, 2'h3, 2'h3, 2'h1};

    sirc_top dut (.sys_clk_i, .reset_i, .clk_en_i, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .evt_i(evt), .reset_cause_i(cause),
        .brownout_detect_enable_i(bde), .periph_irq_o, .irq_o);

    initial
        forever #2 sys_clk_i = ~sys_clk_i;

    function automatic logic [31:0] mrd(input logic [11:0] a);
        case (a)
            SIRC_FLAGS_ADDR: return {24'h0, m_fl};
            SIRC_ENABLES_ADDR: return {24'h0, m_en};
            SIRC_CORE_ADDR: return {24'h0, m_co};
            SIRC_STAT_ADDR: return {30'h0, m_st};
            SIRC_MASK_ADDR: return {30'h0, m_mk};
            SIRC_PWR_ADDR: return {30'h0, m_pw};
            default: return 32'h0;
        endcase
    endfunction : mrd

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input bit b);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        while (pready !== 1'b1)
            @(posedge sys_clk_i);
        rd_q = prdata;
        err_q = pslverr;
        penable <= 1'b0;
        if (!b)
        begin
            psel <= 1'b0;
            @(posedge sys_clk_i);
        end
        `CHK("slverr", !(a inside {AD}), err_q)
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input bit b = 0);
        apb(1'b1, a, {24'h0, d}, b);
        case (a)
            SIRC_FLAGS_ADDR: m_fl = d & SIRC_IMPL_MASK;
            SIRC_ENABLES_ADDR: m_en = d & SIRC_IMPL_MASK;
            SIRC_CORE_ADDR: m_co = d & SIRC_CORE_MASK;
            SIRC_STAT_ADDR: m_st = m_st & ~d[1:0];
            SIRC_MASK_ADDR: m_mk = d[1:0];
            SIRC_PWR_ADDR: m_pw = d[1:0];
            default: ;
        endcase
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] k = 32'hFFFFFFFF);
        apb(1'b0, a, 32'h0, 1'b0);
        `CHK("read", mrd(a) & k, rd_q & k)
    endtask : rd

    task automatic pulse(input sirc_evt_t e);
        evt <= e;
        @(posedge sys_clk_i);
        evt <= 2'h0;
        m_fl = m_fl | {3'h0, e, 3'h0};
        m_st = m_st | e;
    endtask : pulse

    task automatic chk_irq;
        logic p;
        repeat (3) @(posedge sys_clk_i);
        p = |(m_fl & m_en) & m_co[SIRC_PERIPH_EN_BIT];
        `CHK("periph_irq", p, periph_irq_o)
        `CHK("irq", p & m_co[SIRC_GLOBAL_EN_BIT] | |(m_st & m_mk), irq_o)
    endtask : chk_irq

    task automatic rst(input sirc_cause_t c, input logic de);
        cause <= c;
        bde <= de;
        reset_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        {m_fl, m_en, m_co, m_st, m_mk} = 28'h0;
        repeat (2) @(posedge sys_clk_i);
    endtask : rst

    task automatic complete_run;
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        complete_run();
    end

    initial
    begin
        rst(SIRC_CAUSE_POR, 1'b1);
        m_pw[1] = 1'b0;
        foreach (AD[i])
            rd(AD[i], (i == 5) ? 32'h2 : 32'hFFFFFFFF);
        wr(SIRC_PWR_ADDR, 8'h3);
        rd(SIRC_PWR_ADDR);
        for (int b = 1; b < 8; b++)
        begin
            // Reserved positions 6 and 0 are never written
            if (b == 6)
                continue;
            wr(SIRC_FLAGS_ADDR, 8'h1 << b);
            rd(SIRC_FLAGS_ADDR);
            wr(SIRC_ENABLES_ADDR, 8'h1 << b, 1);
            rd(SIRC_ENABLES_ADDR);
        end
        wr(12'h00C, 8'hFF);
        rd(12'hFFC);
        for (int i = 0; i < 30; i++)
        begin
            lf = lfsr_next(lf);
            wr(AD[lf[15:8] % 5], lf[7:0] & ((lf[15:8] % 5 < 2) ? 8'hBE : 8'hFF), 1);
            rd(AD[lf[15:8] % 5]);
            chk_irq();
        end
        for (int e = 1; e < 3; e++)
        begin
            wr(SIRC_FLAGS_ADDR, 8'h0);
            wr(SIRC_STAT_ADDR, 8'h3);
            wr(SIRC_ENABLES_ADDR, 8'h0);
            wr(SIRC_MASK_ADDR, 8'h0);
            wr(SIRC_CORE_ADDR, 8'hC0);
            pulse(e[1:0]);
            rd(SIRC_FLAGS_ADDR);
            chk_irq();
            wr(SIRC_ENABLES_ADDR, 8'h18);
            chk_irq();
            wr(SIRC_CORE_ADDR, 8'h40);
            chk_irq();
            rd(SIRC_STAT_ADDR);
            wr(SIRC_MASK_ADDR, e[7:0]);
            chk_irq();
            wr(SIRC_STAT_ADDR, e[7:0]);
            chk_irq();
        end
        // Events while the clock enable is low must leave no trace
        clk_en_i <= 1'b0;
        evt <= 2'h3;
        @(posedge sys_clk_i);
        evt <= 2'h0;
        clk_en_i <= 1'b1;
        rd(SIRC_FLAGS_ADDR);
        rd(SIRC_STAT_ADDR);
        chk_irq();
        foreach (CS[i])
        begin
            wr(SIRC_PWR_ADDR, 8'h3);
            rst(CS[i], 1'b1);
            m_pw = PE[i];
            rd(SIRC_PWR_ADDR);
        end
        // Brown-out bit has no meaning with detection off
        rst(SIRC_CAUSE_BROWNOUT, 1'b0);
        rd(SIRC_PWR_ADDR, 32'h2);
        complete_run();
    end
endmodule : tb_secondary_irq_and_reset_cause
`default_nettype wire

/* rtl/sirc_flag_bit.sv */
`timescale 1ns/1ps
`default_nettype none
module sirc_flag_bit
    import sirc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Control
    input wire logic set_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    input wire logic w1c_i,
    output logic flag_o
);

    logic flag_q;
    logic flag_d;

    // Set beats any write in the same cycle
    assign flag_d = set_i ? 1'b1 :
                    wr_i ? (w1c_i ? (flag_q & ~wdata_i) : wdata_i) : flag_q;
    assign flag_o = flag_q;

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            flag_q <= 1'b0;
        else if (clk_en_i)
            flag_q <= flag_d;
    end

endmodule : sirc_flag_bit
`default_nettype wire

/* rtl/sirc_pkg.sv */
`default_nettype none
package sirc_pkg;

    // ****************************************************************
    // Register map: word indices for flags, enables and power (byte address is four times the index), byte addresses for the rest
    // ****************************************************************
    localparam logic [11:0] SIRC_FLAGS_IDX = 12'h00D;
    localparam logic [11:0] SIRC_ENABLES_IDX = 12'h08D;
    localparam logic [11:0] SIRC_PWR_IDX = 12'h08E;
    localparam logic [11:0] SIRC_FLAGS_ADDR = {SIRC_FLAGS_IDX[9:0], 2'h0};
    localparam logic [11:0] SIRC_ENABLES_ADDR = {SIRC_ENABLES_IDX[9:0], 2'h0};
    localparam logic [11:0] SIRC_PWR_ADDR = {SIRC_PWR_IDX[9:0], 2'h0};
    localparam logic [11:0] SIRC_CORE_ADDR = 12'h100;
    localparam logic [11:0] SIRC_STAT_ADDR = 12'h104;
    localparam logic [11:0] SIRC_MASK_ADDR = 12'h108;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int SIRC_NVM_BIT = 4;
    localparam int SIRC_COL_BIT = 3;
    localparam logic [7:0] SIRC_IMPL_MASK = 8'h18;
    localparam int SIRC_POR_BIT = 1;
    localparam int SIRC_BROWNOUT_BIT = 0;
    localparam int SIRC_PERIPH_EN_BIT = 6;
    localparam int SIRC_GLOBAL_EN_BIT = 7;
    localparam logic [7:0] SIRC_CORE_MASK = 8'hC0;
    localparam logic [7:0] SIRC_ZERO8 = 8'h00;
    localparam logic [1:0] SIRC_PWR_RESET = 2'h1;
    localparam int SIRC_NUM_EVT = 2;

    // Causes of the most recent reset
    typedef enum logic [1:0]
    {
        SIRC_CAUSE_POR,
        SIRC_CAUSE_BROWNOUT,
        SIRC_CAUSE_WATCHDOG,
        SIRC_CAUSE_PIN
    } sirc_cause_t;

    // Peripheral events, one-cycle pulses
    typedef struct packed
    {
        logic nvm_write_done;
        logic collision;
    } sirc_evt_t;

endpackage : sirc_pkg
`default_nettype wire

/* rtl/sirc_reset_cause.sv */
`timescale 1ns/1ps
`default_nettype none
module sirc_reset_cause
    import sirc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Cause of the reset just released
    input wire sirc_cause_t cause_i,
    input wire logic brownout_detect_enable_i,
    // Software write
    input wire logic wr_i,
    input wire logic [1:0] wdata_i,
    output logic [1:0] pwr_o
);

    logic [1:0] pwr_q;
    logic [1:0] pwr_d;
    logic capture_q;

    // Cause is captured on the first edge after release, never under reset
    always_comb
    begin
        pwr_d = pwr_q;
        if (capture_q)
        begin
            case (cause_i)
                SIRC_CAUSE_POR: pwr_d[SIRC_POR_BIT] = 1'b0;
                SIRC_CAUSE_BROWNOUT:
                    if (brownout_detect_enable_i)
                        pwr_d[SIRC_BROWNOUT_BIT] = 1'b0;
                default: pwr_d = pwr_q;
            endcase
        end
        else if (wr_i)
            pwr_d = wdata_i;
    end

    assign pwr_o = pwr_q;

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            capture_q <= 1'b1;
        else if (clk_en_i)
            capture_q <= 1'b0;
    end

    // Register survives non-power-on resets, so no reset term here
    always_ff @(posedge sys_clk_i)
    begin
        if (clk_en_i && !reset_i)
            pwr_q <= pwr_d;
    end

endmodule : sirc_reset_cause
`default_nettype wire

/* rtl/sirc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sirc_top
    import sirc_pkg::*;
(
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events and reset cause
    input wire sirc_evt_t evt_i,
    input wire sirc_cause_t reset_cause_i,
    input wire logic brownout_detect_enable_i,
    // Interrupt outputs
    output logic periph_irq_o,
    output logic irq_o
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic wr_en;
    logic sel_flags;
    logic sel_enables;
    logic sel_pwr;
    logic sel_core;
    logic sel_stat;
    logic sel_mask;
    logic mapped;
    assign wr_en = psel & penable & pwrite & clk_en_i;
    assign sel_flags = (paddr == SIRC_FLAGS_ADDR);
    assign sel_enables = (paddr == SIRC_ENABLES_ADDR);
    assign sel_pwr = (paddr == SIRC_PWR_ADDR);
    assign sel_core = (paddr == SIRC_CORE_ADDR);
    assign sel_stat = (paddr == SIRC_STAT_ADDR);
    assign sel_mask = (paddr == SIRC_MASK_ADDR);
    assign mapped = sel_flags | sel_enables | sel_pwr | sel_core | sel_stat | sel_mask;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ****************************************************************
    // Secondary flags, enables, sticky status
    // ****************************************************************
    logic [SIRC_NUM_EVT-1:0] evt_vec;
    logic [SIRC_NUM_EVT-1:0] flag_vec;
    logic [SIRC_NUM_EVT-1:0] stat_vec;
    logic [SIRC_NUM_EVT-1:0] en_vec;
    logic [SIRC_NUM_EVT-1:0] mask_vec;
    logic [SIRC_NUM_EVT-1:0] wbit_fe;
    logic [SIRC_NUM_EVT-1:0] wbit_ms;
    assign evt_vec = {evt_i.nvm_write_done, evt_i.collision};
    assign wbit_fe = {pwdata[SIRC_NVM_BIT], pwdata[SIRC_COL_BIT]};
    // Status and mask use bits 1:0
    assign wbit_ms = pwdata[SIRC_NUM_EVT-1:0];

    genvar gi;
    generate
        for (gi = 0; gi < SIRC_NUM_EVT; gi++)
        begin : g_evt
            // Flag sets on event whatever the enables say
            sirc_flag_bit u_flag (
                .sys_clk_i(sys_clk_i),
                .reset_i(reset_i),
                .clk_en_i(clk_en_i),
                .set_i(evt_vec[gi]),
                .wr_i(wr_en & sel_flags),
                .wdata_i(wbit_fe[gi]),
                .w1c_i(1'b0),
                .flag_o(flag_vec[gi])
            );
            sirc_flag_bit u_en (
                .sys_clk_i(sys_clk_i),
                .reset_i(reset_i),
                .clk_en_i(clk_en_i),
                .set_i(1'b0),
                .wr_i(wr_en & sel_enables),
                .wdata_i(wbit_fe[gi]),
                .w1c_i(1'b0),
                .flag_o(en_vec[gi])
            );
            sirc_flag_bit u_stat (
                .sys_clk_i(sys_clk_i),
                .reset_i(reset_i),
                .clk_en_i(clk_en_i),
                .set_i(evt_vec[gi]),
                .wr_i(wr_en & sel_stat),
                .wdata_i(wbit_ms[gi]),
                .w1c_i(1'b1),
                .flag_o(stat_vec[gi])
            );
            sirc_flag_bit u_mask (
                .sys_clk_i(sys_clk_i),
                .reset_i(reset_i),
                .clk_en_i(clk_en_i),
                .set_i(1'b0),
                .wr_i(wr_en & sel_mask),
                .wdata_i(wbit_ms[gi]),
                .w1c_i(1'b0),
                .flag_o(mask_vec[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Core enable copy (peripheral and global)
    // ****************************************************************
    logic [1:0] core_q;
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            core_q <= 2'b00;
        else if (clk_en_i && wr_en && sel_core)
            core_q <= {pwdata[SIRC_GLOBAL_EN_BIT], pwdata[SIRC_PERIPH_EN_BIT]};
    end

    // ****************************************************************
    // Reset cause
    // ****************************************************************
    logic [1:0] pwr_bits;
    sirc_reset_cause u_cause (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .cause_i(reset_cause_i),
        .brownout_detect_enable_i(brownout_detect_enable_i),
        .wr_i(wr_en & sel_pwr),
        .wdata_i(pwdata[1:0]),
        .pwr_o(pwr_bits)
    );

    // ****************************************************************
    // Interrupt generation
    // ****************************************************************
    logic periph_pend;
    logic periph_irq_d;
    logic irq_d;
    logic periph_irq_q;
    logic irq_q;
    assign periph_pend = |(flag_vec & en_vec);
    assign periph_irq_d = periph_pend & core_q[0];
    assign irq_d = (periph_irq_d & core_q[1]) | |(stat_vec & mask_vec);
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            periph_irq_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            periph_irq_q <= periph_irq_d;
            irq_q <= irq_d;
        end
    end
    assign periph_irq_o = periph_irq_q;
    assign irq_o = irq_q;

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [7:0] rd_fe_flags;
    logic [7:0] rd_fe_en;
    logic [7:0] rd_byte;
    // Unimplemented and reserved positions read zero
    assign rd_fe_flags = {3'h0, flag_vec[1], flag_vec[0], 3'h0};
    assign rd_fe_en = {3'h0, en_vec[1], en_vec[0], 3'h0};
    assign rd_byte = sel_flags ? rd_fe_flags :
                     sel_enables ? rd_fe_en :
                     sel_pwr ? {6'h00, pwr_bits} :
                     sel_core ? {core_q, 6'h00} :
                     sel_stat ? {6'h00, stat_vec} :
                     sel_mask ? {6'h00, mask_vec} : SIRC_ZERO8;
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            prdata <= 32'h0000_0000;
        else if (clk_en_i && psel && !penable && !pwrite)
            prdata <= {24'h000000, rd_byte};
    end

endmodule : sirc_top
`default_nettype wire
